// ==== include/tc_consts.svh ====
/*
  Offsets, field positions and state counts of the transfer controller.
  Assumes it is included by its bare name before any code that uses it.
*/
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH

`define TC_PRIO_STATES 8'h02
`define TC_INS_ONCHIP 8'h26
`define TC_INS_EXT_BASE 8'h4A
`define TC_INS_EXT_W 8'h10
`define TC_STK_MIN_ON 8'h10
`define TC_STK_MAX_ON 8'h15
`define TC_STK_MIN_EXT 8'h1C
`define TC_STK_MIN_EXT_W 8'h06
`define TC_STK_MAX_EXT 8'h29
`define TC_STK_MAX_EXT_W 8'h0A
`define TC_XFER_BASE 8'h1A
`define TC_INC_STATES 8'h02
`define TC_ACC_STATES 8'h02
`define TC_SETTLE 8'h03

`define TC_VEC_BASE_MIN 16'h00A0
`define TC_VEC_BASE_MAX 16'h0140
`define TC_DESC_LAST 3'h7

`define TC_MODE_WORD 15
`define TC_MODE_SI 14
`define TC_MODE_DI 13

`define TC_REG_CTRL 8'h00
`define TC_REG_XEN 8'h04
`define TC_REG_IE 8'h08
`define TC_REG_PRIO 8'h0C
`define TC_REG_STAT 8'h10
`define TC_REG_MASK 8'h14
`define TC_REG_STATE 8'h18
`define TC_REG_LAST 8'h1C

`define TC_CTRL_MAX 0
`define TC_CTRL_INSEXT 1
`define TC_CTRL_STKEXT 2
`define TC_CTRL_WAIT 5:4
`define TC_CTRL_LEVEL 10:8
`define TC_ST_XFER 0
`define TC_ST_END 1

`endif

// ==== include/tc_pkg.sv ====
/*
  Types shared by the transfer controller files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tc_pkg;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_PRIO = 11'h002,
    ST_INSN = 11'h004,
    ST_VEC = 11'h008,
    ST_LOAD = 11'h010,
    ST_READ = 11'h020,
    ST_WRITE = 11'h040,
    ST_WBACK = 11'h080,
    ST_PAD = 11'h100,
    ST_STACK = 11'h200,
    ST_SETTLE = 11'h400
  } tc_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] cnt;
  } desc_s;

  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } pick_s;
endpackage

// ==== hdl/state_timer.sv ====
/*
  Down counter that holds a phase for one state more than the loaded value.
  Assumes load is raised only in the cycle that enters the timed phase.
*/
`timescale 1ns/10ps
`default_nettype none

module state_timer #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status.
  output logic done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  if (W < 2) begin : g_chk
    $error("state_timer width too small");
  end

  always_comb begin
    if (load) begin
      next_cnt = value;
    end else if (cnt != '0) begin
      next_cnt = W'(cnt - 1'b1);
    end else begin
      next_cnt = cnt;
    end
    done = (cnt == '0);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

`default_nettype wire

// ==== hdl/transfer_controller.sv ====
/*
  Interrupt-triggered transfer controller: arbitration, descriptor load,
  one byte or word move, write-back, and the completion interrupt.
  Assumes a byte-wide memory on ref_clk that answers each held request
  with a one-cycle mem_ack, and interrupt requests arriving as pins.
  // Operation
  // - Priority decision and mask comparison take two states.
  // - Waiting on an on-chip instruction adds at most 38 states.
  // - Waiting on an external instruction takes 74 + 16m states.
  // - On-chip stacking and prefetch take 16 states, or 21 in maximum mode.
  // - External stacking takes 28 + 6m states, or 41 + 10m in maximum mode.
  // - Descriptor is loaded from where the source's vector entry points.
  // - Route only when enabled, above mask level, and source enabled.
  // - Each accepted interrupt starts exactly one transfer.
  // - After the last transfer a CPU interrupt of the same type follows.
  // - A zero count gives an effective count of 65,536.
  // - Minimum-mode vector: upper pointer byte even, lower byte odd.
  // - Descriptor is four consecutive words in fixed order.
  // - A transfer takes 26 states plus increments plus access states.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tc_consts.svh"

module transfer_controller #(
  parameter int NSRC = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt sources.
  input wire logic [NSRC-1:0] irq_req,
  output logic [NSRC-1:0] req_ack,
  // Memory bus.
  output tc_pkg::mem_req_s mem_o,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // CPU side.
  output logic cpu_irq,
  output logic [2:0] cpu_irq_type,
  output logic irq,
  output logic busy
);
  if (NSRC < 1 || NSRC > 8) begin : g_chk
    $error("NSRC must lie between 1 and 8");
  end

  // Software-visible state.
  logic [31:0] ctrl, next_ctrl;
  logic [NSRC-1:0] xen, next_xen;
  logic [NSRC-1:0] ie, next_ie;
  logic [3*NSRC-1:0] prio, next_prio;
  logic [1:0] status, next_status;
  logic [1:0] mask, next_mask;
  logic [31:0] next_rdata;
  logic next_irq;

  // Request synchroniser.
  logic [NSRC-1:0] irq_meta, irq_sync;

  // Engine state.
  tc_pkg::tc_state_e state, next_state;
  tc_pkg::mem_req_s next_mem;
  tc_pkg::desc_s desc, next_desc;
  logic [15:0] ptr, next_ptr;
  logic [15:0] data, next_data;
  logic [2:0] sel, next_sel;
  logic [2:0] bi, next_bi;
  logic [7:0] elapsed, next_elapsed;
  logic [NSRC-1:0] next_ack;
  logic next_cpu_irq, next_busy;
  logic [2:0] next_cpu_type;
  logic tmr_load, tmr_done;
  logic [7:0] tmr_val;
  logic ev_xfer, ev_end;
  tc_pkg::pick_s win;
  logic [7:0] m8, ins_len, stk_len, xfer_len;
  logic last_data;

  // Highest level wins; ties go to the lowest source number.
  function automatic tc_pkg::pick_s pick(input logic [NSRC-1:0] ok,
                                         input logic [3*NSRC-1:0] lv);
    tc_pkg::pick_s p;
    logic [2:0] best;
    p = '0;
    best = 3'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (ok[i] && (!p.hit || lv[3*i +: 3] > best)) begin
        p.hit = 1'b1;
        p.idx = 3'(i);
        best = lv[3*i +: 3];
      end
    end
    return p;
  endfunction

  // Words stand in order mode, source, destination, count; high byte first.
  function automatic logic [7:0] desc_byte(input tc_pkg::desc_s d,
                                           input logic [2:0] k);
    logic [63:0] flat;
    flat = d;
    return flat[8*(7 - k) +: 8];
  endfunction

  state_timer #(.W(8)) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  always_comb begin
    logic [NSRC-1:0] ok;
    ok = '0;
    for (int i = 0; i < NSRC; i++) begin
      ok[i] = irq_sync[i] && xen[i] && ie[i] &&
              (prio[3*i +: 3] > ctrl[`TC_CTRL_LEVEL]);
    end
    win = pick(ok, prio);
    m8 = {6'h00, ctrl[`TC_CTRL_WAIT]};
    ins_len = ctrl[`TC_CTRL_INSEXT] ?
              8'(`TC_INS_EXT_BASE + `TC_INS_EXT_W * m8) : `TC_INS_ONCHIP;
    unique case ({ctrl[`TC_CTRL_STKEXT], ctrl[`TC_CTRL_MAX]})
      2'h0: stk_len = `TC_STK_MIN_ON;
      2'h1: stk_len = `TC_STK_MAX_ON;
      2'h2: stk_len = 8'(`TC_STK_MIN_EXT + `TC_STK_MIN_EXT_W * m8);
      2'h3: stk_len = 8'(`TC_STK_MAX_EXT + `TC_STK_MAX_EXT_W * m8);
    endcase
    xfer_len = 8'(`TC_XFER_BASE + (desc.mode[`TC_MODE_SI] ? `TC_INC_STATES : 8'h00) +
                  (desc.mode[`TC_MODE_DI] ? `TC_INC_STATES : 8'h00) +
                  `TC_ACC_STATES + `TC_ACC_STATES);
    last_data = !desc.mode[`TC_MODE_WORD] || bi[0];
  end

  // Engine next state.
  always_comb begin
    next_state = state;
    next_desc = desc;
    next_ptr = ptr;
    next_data = data;
    next_sel = sel;
    next_bi = bi;
    next_elapsed = (elapsed == 8'hFF) ? elapsed : 8'(elapsed + 8'h01);
    next_ack = '0;
    next_cpu_irq = 1'b0;
    next_cpu_type = cpu_irq_type;
    tmr_load = 1'b0;
    tmr_val = 8'h00;
    ev_xfer = 1'b0;
    ev_end = 1'b0;
    unique case (state)
      tc_pkg::ST_IDLE: begin
        if (win.hit) begin
          next_sel = win.idx;
          tmr_load = 1'b1;
          tmr_val = 8'(`TC_PRIO_STATES - 8'h01);
          next_state = tc_pkg::ST_PRIO;
        end
      end
      tc_pkg::ST_PRIO: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = 8'(ins_len - 8'h01);
          next_state = tc_pkg::ST_INSN;
        end
      end
      tc_pkg::ST_INSN: begin
        if (tmr_done) begin
          next_bi = 3'h0;
          next_state = tc_pkg::ST_VEC;
        end
      end
      tc_pkg::ST_VEC: begin
        if (mem_ack) begin
          next_bi = 3'(bi + 3'h1);
          if (!bi[0]) begin
            next_ptr[15:8] = mem_rdata;
          end else begin
            next_ptr[7:0] = mem_rdata;
            next_bi = 3'h0;
            next_elapsed = 8'h00;
            next_state = tc_pkg::ST_LOAD;
          end
        end
      end
      tc_pkg::ST_LOAD: begin
        if (mem_ack) begin
          next_desc = (desc & ~(64'hFF << (8 * (7 - bi)))) |
                      (64'(mem_rdata) << (8 * (7 - bi)));
          next_bi = 3'(bi + 3'h1);
          if (bi == `TC_DESC_LAST) begin
            next_bi = 3'h0;
            next_state = tc_pkg::ST_READ;
          end
        end
      end
      tc_pkg::ST_READ: begin
        if (mem_ack) begin
          next_bi = 3'(bi + 3'h1);
          if (desc.mode[`TC_MODE_WORD] && !bi[0]) begin
            next_data[15:8] = mem_rdata;
          end else begin
            next_data[7:0] = mem_rdata;
          end
          if (last_data) begin
            next_bi = 3'h0;
            next_state = tc_pkg::ST_WRITE;
          end
        end
      end
      tc_pkg::ST_WRITE: begin
        if (mem_ack) begin
          next_bi = 3'(bi + 3'h1);
          if (last_data) begin
            if (desc.mode[`TC_MODE_SI]) begin
              next_desc.src = 16'(desc.src + {14'h0000, desc.mode[`TC_MODE_WORD],
                                              !desc.mode[`TC_MODE_WORD]});
            end
            if (desc.mode[`TC_MODE_DI]) begin
              next_desc.dst = 16'(desc.dst + {14'h0000, desc.mode[`TC_MODE_WORD],
                                              !desc.mode[`TC_MODE_WORD]});
            end
            next_desc.cnt = 16'(desc.cnt - 16'h0001);
            next_bi = 3'h0;
            next_state = tc_pkg::ST_WBACK;
          end
        end
      end
      tc_pkg::ST_WBACK: begin
        if (mem_ack) begin
          next_bi = 3'(bi + 3'h1);
          if (bi == `TC_DESC_LAST) begin
            next_bi = 3'h0;
            ev_xfer = 1'b1;
            next_state = tc_pkg::ST_PAD;
          end
        end
      end
      tc_pkg::ST_PAD: begin
        if (elapsed >= 8'(xfer_len - 8'h02)) begin
          next_ack[sel] = 1'b1;
          tmr_load = 1'b1;
          if (desc.cnt == 16'h0000) begin
            tmr_val = 8'(stk_len - 8'h01);
            next_state = tc_pkg::ST_STACK;
          end else begin
            tmr_val = 8'(`TC_SETTLE - 8'h01);
            next_state = tc_pkg::ST_SETTLE;
          end
        end
      end
      tc_pkg::ST_STACK: begin
        if (tmr_done) begin
          next_cpu_irq = 1'b1;
          next_cpu_type = sel;
          ev_end = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 8'(`TC_SETTLE - 8'h01);
          next_state = tc_pkg::ST_SETTLE;
        end
      end
      tc_pkg::ST_SETTLE: begin
        if (tmr_done) begin
          next_state = tc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = tc_pkg::ST_IDLE;
      end
    endcase
    next_busy = (next_state != tc_pkg::ST_IDLE);
  end

  // Bus request for the access that the next state makes.
  always_comb begin
    next_mem = '0;
    unique case (next_state)
      tc_pkg::ST_VEC: begin
        next_mem.req = 1'b1;
        next_mem.addr = ctrl[`TC_CTRL_MAX] ?
                        16'(`TC_VEC_BASE_MAX + {11'h000, next_sel, 2'h2} + next_bi) :
                        16'(`TC_VEC_BASE_MIN + {12'h000, next_sel, 1'b0} + next_bi);
      end
      tc_pkg::ST_LOAD: begin
        next_mem.req = 1'b1;
        next_mem.addr = 16'(next_ptr + {13'h0000, next_bi});
      end
      tc_pkg::ST_READ: begin
        next_mem.req = 1'b1;
        next_mem.addr = 16'(next_desc.src + {13'h0000, next_bi});
      end
      tc_pkg::ST_WRITE: begin
        next_mem.req = 1'b1;
        next_mem.we = 1'b1;
        next_mem.addr = 16'(next_desc.dst + {13'h0000, next_bi});
        next_mem.wdata = (next_desc.mode[`TC_MODE_WORD] && !next_bi[0]) ?
                         next_data[15:8] : next_data[7:0];
      end
      tc_pkg::ST_WBACK: begin
        next_mem.req = 1'b1;
        next_mem.we = 1'b1;
        next_mem.addr = 16'(next_ptr + {13'h0000, next_bi});
        next_mem.wdata = desc_byte(next_desc, next_bi);
      end
      default: begin
        next_mem = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= tc_pkg::ST_IDLE;
      desc <= '0;
      ptr <= 16'h0000;
      data <= 16'h0000;
      sel <= 3'h0;
      bi <= 3'h0;
      elapsed <= 8'h00;
      req_ack <= '0;
      cpu_irq <= 1'b0;
      cpu_irq_type <= 3'h0;
      busy <= 1'b0;
      mem_o <= '0;
    end else begin
      state <= next_state;
      desc <= next_desc;
      ptr <= next_ptr;
      data <= next_data;
      sel <= next_sel;
      bi <= next_bi;
      elapsed <= next_elapsed;
      req_ack <= next_ack;
      cpu_irq <= next_cpu_irq;
      cpu_irq_type <= next_cpu_type;
      busy <= next_busy;
      mem_o <= next_mem;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      irq_meta <= irq_req;
      irq_sync <= irq_meta;
    end
  end

  // Register file; a status event wins over a clear in the same cycle.
  always_comb begin
    next_ctrl = ctrl;
    next_xen = xen;
    next_ie = ie;
    next_prio = prio;
    next_mask = mask;
    next_status = status;
    next_rdata = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `TC_REG_CTRL: next_ctrl = reg_wdata;
        `TC_REG_XEN: next_xen = reg_wdata[NSRC-1:0];
        `TC_REG_IE: next_ie = reg_wdata[NSRC-1:0];
        `TC_REG_PRIO: next_prio = reg_wdata[3*NSRC-1:0];
        `TC_REG_STAT: next_status = status & ~reg_wdata[1:0];
        `TC_REG_MASK: next_mask = reg_wdata[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    next_status[`TC_ST_XFER] = next_status[`TC_ST_XFER] | ev_xfer;
    next_status[`TC_ST_END] = next_status[`TC_ST_END] | ev_end;
    if (reg_rd) begin
      unique case (reg_addr)
        `TC_REG_CTRL: next_rdata = ctrl;
        `TC_REG_XEN: next_rdata = 32'(xen);
        `TC_REG_IE: next_rdata = 32'(ie);
        `TC_REG_PRIO: next_rdata = 32'(prio);
        `TC_REG_STAT: next_rdata = 32'(status);
        `TC_REG_MASK: next_rdata = 32'(mask);
        `TC_REG_STATE: next_rdata = {13'h0000, desc.cnt == 16'h0000, sel, 4'h0, state};
        `TC_REG_LAST: next_rdata = {16'h0000, desc.cnt};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl <= 32'h0000_0000;
      xen <= '0;
      ie <= '0;
      prio <= '0;
      status <= 2'h0;
      mask <= 2'h0;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      xen <= next_xen;
      ie <= next_ie;
      prio <= next_prio;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end
endmodule

`default_nettype wire

// ==== verification/mem_model.sv ====
/*
  Byte-wide memory standing on the far side of the transfer controller.
  Assumes requests held until ack; lat sets the extra wait before each ack.
*/
`timescale 1ns/10ps
`default_nettype none

module mem_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request side.
  input wire tc_pkg::mem_req_s mem_i,
  input wire logic [1:0] lat,
  // Answer side.
  output logic [7:0] rdata,
  output logic ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] waited;

  // Read data is only valid in the ack cycle; it toggles otherwise.
  always @(posedge ref_clk) begin
    rdata <= ~rdata;
    ack <= 1'b0;
    if (!rst_n) begin
      waited <= 2'h0;
    end else if (mem_i.req && !ack && waited == lat) begin
      ack <= 1'b1;
      waited <= 2'h0;
      if (mem_i.we) begin
        mem[mem_i.addr] <= mem_i.wdata;
      end else begin
        rdata <= mem[mem_i.addr];
      end
    end else if (mem_i.req && !ack) begin
      waited <= waited + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tc_checker_assertions.sv ====
/*
  Port-level checker for the transfer controller.
  Assumes one clock domain, ref_clk, with rst_n synchronous and active low.
*/
`timescale 1ns/10ps
`default_nettype none

module tc_checker #(
  parameter int NSRC = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Engine outputs and the memory ack.
  input wire logic [NSRC-1:0] req_ack,
  input wire tc_pkg::mem_req_s mem_o,
  input wire logic mem_ack,
  input wire logic cpu_irq,
  input wire logic [2:0] cpu_irq_type,
  input wire logic busy
);
  logic [7:0] since_busy;
  logic [7:0] since_ack;

  // Counts busy cycles and cycles since the last source release.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !busy) since_busy <= 8'h00;
    else if (since_busy != 8'hFF) since_busy <= since_busy + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || req_ack != '0) since_ack <= 8'h00;
    else if (since_ack != 8'hFF) since_ack <= since_ack + 8'h01;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_hold;
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("memory request changed before ack");
  property p_first; mem_o.req |-> since_busy >= 8'd40; endproperty
  a_first: assert property (p_first)
    else $error("memory access before decision and instruction wait");
  property p_ack; req_ack != '0 |-> $onehot(req_ack) ##1 req_ack == '0; endproperty
  a_ack: assert property (p_ack)
    else $error("source release not a single one-cycle pulse");
  property p_bus; req_ack != '0 |-> busy && !mem_o.req; endproperty
  a_bus: assert property (p_bus)
    else $error("source released while memory still in use");
  property p_settle; req_ack != '0 |-> busy [*3]; endproperty
  a_settle: assert property (p_settle)
    else $error("engine idle too soon after release");
  property p_cirq; cpu_irq |-> busy ##1 !cpu_irq; endproperty
  a_cirq: assert property (p_cirq)
    else $error("completion interrupt not a pulse inside a transfer");
  property p_type; $changed(cpu_irq_type) |-> cpu_irq; endproperty
  a_type: assert property (p_type)
    else $error("interrupt type changed without completion interrupt");
  property p_stack; cpu_irq |-> since_ack >= 8'd15; endproperty
  a_stack: assert property (p_stack)
    else $error("completion interrupt before register save time");
  property p_idle; !busy |-> !mem_o.req && req_ack == '0 && !cpu_irq; endproperty
  a_idle: assert property (p_idle)
    else $error("activity while engine idle");
endmodule

bind transfer_controller tc_checker #(.NSRC(NSRC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .req_ack(req_ack), .mem_o(mem_o),
  .mem_ack(mem_ack), .cpu_irq(cpu_irq), .cpu_irq_type(cpu_irq_type), .busy(busy)
);
`default_nettype wire

// ==== verification/transfer_controller_tb_top.sv ====
/*
  Self-checking bench: register setup, accepted and refused requests.
  Assumes package, header, design, checker and memory model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tc_consts.svh"

module transfer_controller_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] req_ack;
  tc_pkg::mem_req_s mem_o;
  logic [7:0] mem_rdata;
  logic mem_ack, cpu_irq, irq, busy;
  logic [2:0] cpu_irq_type;
  logic [1:0] lat = 2'h0;
  logic rd_d = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t_ack = 0;
  int t_irq = 0;
  logic [31:0] q_rd [$];
  logic [2:0] q_irq [$];

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  transfer_controller #(.NSRC(8)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .req_ack(req_ack), .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .cpu_irq(cpu_irq), .cpu_irq_type(cpu_irq_type), .irq(irq), .busy(busy)
  );
  mem_model u_mem (
    .ref_clk(ref_clk), .rst_n(rst_n), .mem_i(mem_o), .lat(lat),
    .rdata(mem_rdata), .ack(mem_ack)
  );

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_mem(input logic [15:0] a, input logic [7:0] e);
    cmp($sformatf("mem %h", a), {24'h0, e}, {24'h0, u_mem.mem[a]});
  endtask
  task automatic put16(input logic [15:0] a, input logic [15:0] v);
    u_mem.mem[a] = v[15:8];
    u_mem.mem[a + 16'h1] = v[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q_rd.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Raises source 1, measures busy-to-first-access cycles, drops it on release.
  task automatic fire(input logic [7:0] d, output int n);
    int i;
    u_mem.mem[16'hFEDD] = d;
    irq_req <= 8'h02;
    i = 0;
    do @(negedge ref_clk); while (busy !== 1'b1 && ++i < 50);
    n = 1;
    do @(negedge ref_clk); while (mem_o.req !== 1'b1 && ++n < 400);
    do @(negedge ref_clk); while (req_ack[1] !== 1'b1 && ++i < 900);
    @(posedge ref_clk);
    irq_req <= 8'h00;
    do @(negedge ref_clk); while (busy !== 1'b0 && ++i < 999);
    @(posedge ref_clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Result watcher: register reads, completion interrupts, timeout.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (req_ack[1] === 1'b1) t_ack <= cyc;
    if (cpu_irq === 1'b1) begin
      t_irq <= cyc;
      if (q_irq.size() == 0) cmp("cpu_irq", 32'h0, 32'h1);
      else cmp("cpu_irq_type", q_irq.pop_front(), cpu_irq_type);
    end
    if (rd_d) cmp("reg_rdata", q_rd.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    logic [7:0] d;
    int n;
    int m;
    int lo;
    void'($urandom(32'h97f1));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    put16(16'h00A2, 16'hFB80);
    put16(16'hFB80, 16'h2000);
    put16(16'hFB82, 16'hFEDD);
    put16(16'hFB84, 16'hFC00);
    put16(16'hFB86, 16'h0002);
    wr(`TC_REG_CTRL, 32'h400);
    wr(`TC_REG_XEN, 32'h2);
    wr(`TC_REG_IE, 32'h2);
    wr(`TC_REG_PRIO, 32'h28);
    wr(`TC_REG_MASK, 32'h3);
    rd(`TC_REG_XEN, 32'h2);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    rd(`TC_REG_STAT, 32'h0);
    $display("test registers done");
    d = 8'($urandom);
    fire(d, n);
    cmp("insn wait", 32'h1, n >= 40 && n <= 42);
    chk_mem(16'hFC00, d);
    chk_mem(16'hFB83, 8'hDD);
    chk_mem(16'hFB85, 8'h01);
    chk_mem(16'hFB87, 8'h01);
    cmp("irq", 32'h1, irq);
    rd(`TC_REG_STAT, 32'h1);
    wr(`TC_REG_STAT, 32'h3);
    rd(`TC_REG_STAT, 32'h0);
    $display("test first transfer done");
    d = 8'($urandom);
    q_irq.push_back(3'h1);
    fire(d, n);
    chk_mem(16'hFC01, d);
    chk_mem(16'hFB87, 8'h00);
    cmp("stack", 32'h1, (t_irq - t_ack) inside {[16:18]});
    rd(`TC_REG_STAT, 32'h3);
    wr(`TC_REG_LAST, 32'h5);
    rd(`TC_REG_LAST, 32'h0);
    wr(`TC_REG_STAT, 32'h3);
    $display("test last transfer done");
    for (int k = 0; k < 3; k++) begin
      wr(`TC_REG_PRIO, k == 0 ? 32'h20 : 32'h28);
      wr(`TC_REG_XEN, k == 1 ? 32'h0 : 32'h2);
      wr(`TC_REG_IE, k == 2 ? 32'h0 : 32'h2);
      irq_req <= 8'h02;
      repeat (60) @(negedge ref_clk);
      cmp("busy", 32'h0, busy);
      @(posedge ref_clk);
      irq_req <= 8'h00;
      repeat (4) @(posedge ref_clk);
    end
    wr(`TC_REG_IE, 32'h2);
    $display("test refusals done");
    m = $urandom_range(3, 0);
    lat <= 2'h2;
    wr(`TC_REG_CTRL, 32'h402 | (m << 4));
    d = 8'($urandom);
    fire(d, n);
    cmp("ext wait", 32'h1, n >= 76 + 16 * m && n <= 78 + 16 * m);
    chk_mem(16'hFB86, 8'hFF);
    chk_mem(16'hFB87, 8'hFF);
    chk_mem(16'hFC02, d);
    $display("test zero count done");
    put16(16'h0146, 16'hFB80);
    for (int j = 0; j < 2; j++) begin
      put16(16'hFB86, 16'h0001);
      wr(`TC_REG_CTRL, j == 0 ? 32'h406 | (m << 4) : 32'h401);
      lo = j == 0 ? 28 + 6 * m : 21;
      q_irq.push_back(3'h1);
      d = 8'($urandom);
      fire(d, n);
      chk_mem(16'(16'hFC03 + j), d);
      cmp("stack len", 32'h1, (t_irq - t_ack) inside {[lo:lo + 2]});
    end
    $display("test stack lengths done");
    wr(`TC_REG_IE, 32'h0);
    rd(`TC_REG_STATE, 32'h0004_8001);
    final_report();
  end
endmodule
`default_nettype wire
